//--- logic/csio_pkg.sv
// Constants, field codes and carrier types of the clocked serial port.
// Assumes a single system clock; software drives the control fields as levels.
// Operation
// - Clock select code 111 takes the shift clock from the pin; codes 000-101 divide.
// - Codes 000-101 give six divided rates; 000 may use the slow clock; 110 unused.
// - Internal clock drives the clock pin, which is high when a transfer starts.
// - Internal clock stops and holds the shift while software lags the buffer.
// - Transmit bits change on the falling clock pin edge.
// - Receive bits are sampled on the rising clock pin edge.
// - Four-bit words use the low nibble; received upper nibble is zero.
// - Every word travels least significant bit first.
// - One to eight words per batch, then the completion interrupt pulses.
// - Transmit moves the next buffer word into the shifter after each word.
// - Transmit batch finished with empty buffer raises the buffer-empty interrupt.
// - Internal transmit waits after a batch until any buffer word is written.
// - A write (transmit) or read (receive) of any buffer word, even outside the count, releases the wait.
// - Run cleared while transmitting: finish the batch, then go inactive.
// - Abort ends the transfer at once and drops partial receive data.
// - External transmit without new data sends one dummy word, then ends.
// - Receive stores each word and signals buffer full after the batch.
// - Internal receive waits with clock stopped until any buffer word is read.
// - External receive with unread data drops the new word and stops.
// - Run cleared while receiving: store the word in progress, then stop.
// - Words go out and come in from buffer word zero upward.
package csio_pkg;

  localparam int          WORD_W       = 8;
  localparam int          IDX_W        = 3;
  localparam int          NIB_W        = 4;

  // Clock select codes and the divider exponent of each internal rate
  localparam logic [2:0]  CLK_SLOWEST  = 3'h0;
  localparam logic [2:0]  CLK_UNUSED   = 3'h6;
  localparam logic [2:0]  CLK_EXT      = 3'h7;
  localparam int          EXP_CODE0    = 13;
  localparam int          EXP_CODE1    = 8;
  localparam int          EXP_CODE2    = 7;
  localparam int          EXP_CODE3    = 6;
  localparam int          EXP_CODE4    = 5;
  localparam int          EXP_CODE5    = 4;
  localparam int          EXP_SLOW     = 5;

  // Transfer mode codes; the combined transmit/receive code is not served here
  localparam logic [2:0]  MODE_TX8     = 3'h0;
  localparam logic [2:0]  MODE_TX4     = 3'h2;
  localparam logic [2:0]  MODE_RX8     = 3'h5;
  localparam logic [2:0]  MODE_RX4     = 3'h6;

  localparam logic [7:0]  DUMMY_WORD   = 8'hFF;
  localparam logic [7:0]  RDATA_RESET  = 8'h00;
  localparam logic        SCK_IDLE     = 1'b1;

  typedef struct packed {
    logic [2:0] clock_select;
    logic [2:0] direction_mode_select;
    logic [2:0] word_count;
    logic       prescaler_tap_select;
    logic       slow_mode;
  } csio_cfg_t;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [IDX_W-1:0]   addr;
    logic [WORD_W-1:0]  wdata;
  } csio_buf_req_t;

  typedef struct packed {
    logic transfer_active_flag;
    logic shift_active;
    logic auto_wait;
  } csio_status_t;

endpackage

//--- logic/csio_core.sv
// Clocked serial port: divider, shift engine and eight-word buffer.
// Assumes control fields are steady during a transfer and pins are asynchronous.
`timescale 1ns/1ns
module csio_core #(
  parameter int DIV_W = 12
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire csio_pkg::csio_cfg_t     cfg,
  input  wire logic                    transfer_run,
  input  wire logic                    transfer_abort,
  input  wire csio_pkg::csio_buf_req_t host,
  output logic [7:0]                   buf_rdata,
  output csio_pkg::csio_status_t       status,
  output logic                         serial_done_interrupt,
  input  wire logic                    lf_clk,
  input  wire logic                    sck_in,
  output logic                         sck_out,
  output logic                         sck_oe,
  output logic                         so_out,
  input  wire logic                    si_in
);
  import csio_pkg::*;

  initial begin
    if (DIV_W < EXP_CODE0 - 1) begin
      $error("csio_core: DIV_W too small for the slowest rate");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_WAIT} csio_state_t;

  // True when the low exp-1 bits of the divider are all ones: half a period
  function automatic logic div_tick(input logic [DIV_W-1:0] cnt, input int exp);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((1 << (exp - 1)) - 1);
    return (cnt & mask) == mask;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic                sck_s1;
  logic                sck_s2;
  logic                sck_s3;
  logic                si_s1;
  logic                si_s2;
  logic                lf_s1;
  logic                lf_s2;
  logic                lf_s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_s1 <= 1'b1;
      sck_s2 <= 1'b1;
      sck_s3 <= 1'b1;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
      lf_s1  <= 1'b0;
      lf_s2  <= 1'b0;
      lf_s3  <= 1'b0;
    end else begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      si_s1  <= si_in;
      si_s2  <= si_s1;
      lf_s1  <= lf_clk;
      lf_s2  <= lf_s1;
      lf_s3  <= lf_s2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Rate dividers

  logic [DIV_W-1:0]    div_cnt;
  logic [EXP_SLOW-1:0] lf_cnt;
  logic                lf_rise;

  assign lf_rise = lf_s2 & ~lf_s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      lf_cnt  <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
      if (lf_rise) begin
        lf_cnt <= lf_cnt + EXP_SLOW'(1);
      end
    end
  end

  logic                use_ext;
  logic                use_slow;
  logic                int_tick;

  assign use_ext  = cfg.clock_select == CLK_EXT;
  assign use_slow = cfg.prescaler_tap_select | cfg.slow_mode;

  always_comb begin
    unique case (cfg.clock_select)
      3'h0:    int_tick = use_slow ? (lf_rise & (&lf_cnt[EXP_SLOW-2:0]))
                                   : div_tick(div_cnt, EXP_CODE0);
      3'h1:    int_tick = div_tick(div_cnt, EXP_CODE1);
      3'h2:    int_tick = div_tick(div_cnt, EXP_CODE2);
      3'h3:    int_tick = div_tick(div_cnt, EXP_CODE3);
      3'h4:    int_tick = div_tick(div_cnt, EXP_CODE4);
      3'h5:    int_tick = div_tick(div_cnt, EXP_CODE5);
      default: int_tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shift clock and edge events

  csio_state_t         state;
  logic                sck_int;
  logic                shifting;
  logic                fall_ev;
  logic                rise_ev;

  assign shifting = state == ST_SHIFT;
  // Pin lag of the external clock is two cycles; leaves room for it
  assign fall_ev  = shifting & (use_ext ? (~sck_s2 & sck_s3) : (int_tick & sck_int));
  assign rise_ev  = shifting & (use_ext ? (sck_s2 & ~sck_s3) : (int_tick & ~sck_int));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_int <= SCK_IDLE;
    end else if (!shifting) begin
      sck_int <= SCK_IDLE;
    end else if (!use_ext && int_tick) begin
      sck_int <= ~sck_int;
    end
  end

  assign sck_out = sck_int;
  assign sck_oe  = ~use_ext;

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode and word-end decisions

  logic                is_tx;
  logic                is_rx;
  logic                is_nib;
  logic                mode_ok;
  logic                run_q;
  logic                start;
  logic [2:0]          bit_cnt;
  logic [IDX_W-1:0]    word_idx;
  logic [WORD_W-1:0]   tx_sh;
  logic [WORD_W-1:0]   rx_sh;
  logic [WORD_W-1:0]   rx_next;
  logic [WORD_W-1:0]   rx_word;
  logic                end_after;
  logic                touched;
  logic                unread;
  logic                touch_now;
  logic                word_end;
  logic                batch_end;
  logic                store_en;
  logic [WORD_W-1:0]   mem [0:7];

  assign is_tx   = (cfg.direction_mode_select == MODE_TX8) |
                   (cfg.direction_mode_select == MODE_TX4);
  assign is_rx   = (cfg.direction_mode_select == MODE_RX8) |
                   (cfg.direction_mode_select == MODE_RX4);
  assign is_nib  = (cfg.direction_mode_select == MODE_TX4) |
                   (cfg.direction_mode_select == MODE_RX4);
  assign mode_ok = (is_tx | is_rx) & (cfg.clock_select != CLK_UNUSED);
  assign start   = (state == ST_IDLE) & transfer_run & ~run_q & ~transfer_abort & mode_ok;

  // A write in transmit or a read in receive counts, whatever the address
  assign touch_now = is_tx ? host.wr : host.rd;

  assign word_end  = rise_ev & (bit_cnt == (is_nib ? 3'h3 : 3'h7));
  assign batch_end = word_end & (word_idx == cfg.word_count);
  assign rx_next   = {si_s2, rx_sh[WORD_W-1:1]};
  assign rx_word   = is_nib ? {NIB_W'(0), rx_next[WORD_W-1:NIB_W]} : rx_next;
  // New word is dropped when the last batch was never read
  assign store_en  = word_end & is_rx & ~transfer_abort & ~(use_ext & unread);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= transfer_run;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software access tracking: access wins over the clear at a batch end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      touched <= 1'b0;
      unread  <= 1'b0;
    end else if (start || transfer_abort) begin
      touched <= 1'b0;
      unread  <= 1'b0;
    end else begin
      if (touch_now) begin
        touched <= 1'b1;
      end else if (batch_end || (state == ST_WAIT && touched)) begin
        touched <= 1'b0;
      end
      if (host.rd) begin
        unread <= 1'b0;
      end else if (batch_end && is_rx && !touched) begin
        unread <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transfer engine

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state                 <= ST_IDLE;
      bit_cnt               <= 3'h0;
      word_idx              <= '0;
      tx_sh                 <= '0;
      rx_sh                 <= '0;
      so_out                <= 1'b1;
      end_after             <= 1'b0;
      serial_done_interrupt <= 1'b0;
    end else begin
      serial_done_interrupt <= 1'b0;
      if (transfer_abort) begin
        state     <= ST_IDLE;
        bit_cnt   <= 3'h0;
        end_after <= 1'b0;
      end else if (start) begin
        state     <= ST_SHIFT;
        bit_cnt   <= 3'h0;
        word_idx  <= '0;
        tx_sh     <= mem[0];
        end_after <= 1'b0;
      end else if (state == ST_WAIT) begin
        if (!transfer_run) begin
          state <= ST_IDLE;
        end else if (touched) begin
          state <= ST_SHIFT;
          tx_sh <= mem[0];
        end
      end else if (shifting) begin
        if (fall_ev && is_tx) begin
          so_out <= tx_sh[0];
          tx_sh  <= {1'b0, tx_sh[WORD_W-1:1]};
        end
        if (rise_ev) begin
          rx_sh   <= rx_next;
          bit_cnt <= bit_cnt + 3'h1;
        end
        if (word_end) begin
          bit_cnt <= 3'h0;
          if (is_rx && use_ext && unread) begin
            state <= ST_IDLE;
          end else if (end_after || (is_rx && !transfer_run)) begin
            state <= ST_IDLE;
          end else if (batch_end) begin
            serial_done_interrupt <= 1'b1;
            word_idx              <= '0;
            tx_sh                 <= mem[0];
            if (!transfer_run) begin
              state <= ST_IDLE;
            end else if (touched || touch_now) begin
              state <= ST_SHIFT;
            end else if (!use_ext) begin
              state <= ST_WAIT;
            end else if (is_tx) begin
              tx_sh     <= DUMMY_WORD;
              end_after <= 1'b1;
            end
          end else begin
            word_idx <= word_idx + IDX_W'(1);
            tx_sh    <= mem[word_idx + IDX_W'(1)];
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Word buffer; a received word is stored and a same-cycle write to any slot is lost

  always_ff @(posedge clk) begin
    if (store_en) begin
      mem[word_idx] <= rx_word;
    end else if (host.wr) begin
      mem[host.addr] <= host.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_rdata <= RDATA_RESET;
    end else if (host.rd) begin
      buf_rdata <= mem[host.addr];
    end
  end

  assign status.transfer_active_flag = state != ST_IDLE;
  assign status.shift_active         = shifting;
  assign status.auto_wait            = state == ST_WAIT;

endmodule

//--- verification/csio_checker.sv
// Checker: port-level timing of the clocked serial port.
// Bound to every csio_core; sees only its ports.
`timescale 1ns/1ns
module csio_checker #(
  parameter int DIV_W = 12
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire csio_pkg::csio_cfg_t     cfg,
  input wire logic                    transfer_run,
  input wire logic                    transfer_abort,
  input wire csio_pkg::csio_buf_req_t host,
  input wire logic [7:0]              buf_rdata,
  input wire csio_pkg::csio_status_t  status,
  input wire logic                    serial_done_interrupt,
  input wire logic                    lf_clk,
  input wire logic                    sck_in,
  input wire logic                    sck_out,
  input wire logic                    sck_oe,
  input wire logic                    so_out,
  input wire logic                    si_in
);
  import csio_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic act = status.transfer_active_flag;
  wire logic rx  = cfg.direction_mode_select[2];
  wire logic ok  = cfg.direction_mode_select inside {MODE_TX8, MODE_TX4, MODE_RX8, MODE_RX4};
  ////////////////////////////////////////////////////////////
  sequence start_s;
    $rose(transfer_run) && !act && !transfer_abort && ok && cfg.clock_select != CLK_UNUSED;
  endsequence
  sequence idle_s;
    !act [*2] ##0 sck_oe;
  endsequence
  sequence waiting_s;
    status.auto_wait [*2];
  endsequence
  ////////////////////////////////////////////////////////////
  start_flag_a: assert property (start_s |=> act)
    else $error("start not taken");
  abort_ends_a: assert property (transfer_abort |=> !act)
    else $error("abort did not end transfer");
  unused_clock_a: assert property (cfg.clock_select == CLK_UNUSED && !act |=> !act)
    else $error("start with unused clock code");
  clock_dir_a: assert property ($stable(cfg.clock_select) |-> sck_oe == (cfg.clock_select != CLK_EXT))
    else $error("clock pin direction wrong");
  idle_high_a: assert property (idle_s |-> sck_out)
    else $error("idle clock not high");
  wait_stop_a: assert property (waiting_s |-> sck_out)
    else $error("clock runs during wait");
  tx_edge_a: assert property (status.shift_active && sck_oe && $changed(so_out) |-> !sck_out)
    else $error("data changed off falling edge");
  wait_release_a: assert property (status.auto_wait && (rx ? host.rd : host.wr) |-> ##[1:4] !status.auto_wait)
    else $error("wait not released");
  irq_pulse_a: assert property (serial_done_interrupt |=> !serial_done_interrupt)
    else $error("interrupt longer than a cycle");
endmodule

bind csio_core csio_checker #(.DIV_W(DIV_W)) chk (
  .clk, .rst, .cfg, .transfer_run, .transfer_abort, .host, .buf_rdata, .status,
  .serial_done_interrupt, .lf_clk, .sck_in, .sck_out, .sck_oe, .so_out, .si_in
);

//--- verification/csio_peer.sv
// Serial peer model: captures the outgoing data, feeds the incoming data.
// Makes the external shift clock on request; otherwise it stands high.
`timescale 1ns/1ns
module csio_peer (
  input  wire logic  clk,
  input  wire logic  sck_out,
  input  wire logic  sck_oe,
  input  wire logic  so_out,
  output logic       sck_in,
  output logic       si_in
);
  logic [15:0] cap = 16'h0000;
  logic [15:0] pat = 16'h0000;
  int          n = 0;
  logic        prev = 1'b1;
  wire logic   line = sck_oe ? sck_out : sck_in;

  initial begin
    sck_in = 1'b1;
    si_in  = 1'b0;
  end

  // Edges are seen a clk late, well inside the shortest half period
  always @(posedge clk) begin
    prev <= line;
    if (!prev && line) begin
      cap <= {so_out, cap[15:1]};
      n   <= n + 1;
    end
    if (prev && !line)
      si_in <= pat[n[3:0]];
  end

  // Five cycles per level keeps every shift certain
  task automatic pulse;
    sck_in = 1'b0;
    repeat (5) @(negedge clk);
    sck_in = 1'b1;
    repeat (5) @(negedge clk);
  endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench of the clocked serial port with its serial peer.
// Assumes the package, the core, the peer and the checker compile first.
`timescale 1ns/1ns
module testbench;
  import csio_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          lf_clk = 1'b0;
  logic          transfer_run = 1'b0;
  logic          transfer_abort = 1'b1;
  csio_cfg_t     cfg = '0;
  csio_buf_req_t host = '0;
  logic [7:0]    buf_rdata;
  csio_status_t  status;
  logic          serial_done_interrupt;
  logic          sck_in;
  logic          sck_out;
  logic          sck_oe;
  logic          so_out;
  logic          si_in;
  int            err_count = 0;
  int            checked = 0;
  int            i;

  always #5 clk = ~clk;
  always #2000 lf_clk = ~lf_clk;

  csio_core #(.DIV_W(12)) dut (
    .clk, .rst, .cfg, .transfer_run, .transfer_abort, .host, .buf_rdata, .status,
    .serial_done_interrupt, .lf_clk, .sck_in, .sck_out, .sck_oe, .so_out, .si_in
  );
  csio_peer peer (.clk, .sck_out, .sck_oe, .so_out, .sck_in, .si_in);
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return serial_done_interrupt;
      1: return status.transfer_active_flag;
      default: return status.auto_wait;
    endcase
  endfunction
  // Every wait is bounded; running out ends the run
  task automatic wait_on(input int w, input logic v);
    int k;
    for (k = 0; k < 4000 && pick(w) !== v; k++) tick();
    if (k == 4000) begin
      err_count++;
      print_verdict();
    end
  endtask
  // A clock edge passes after each access so that back-to-back calls never
  // lower and raise the strobe in one time step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host = '{1'b1, 1'b0, a, d};
    tick();
    host = '0;
    tick();
  endtask
  task automatic rd(input logic [2:0] a);
    host = '{1'b0, 1'b1, a, 8'h00};
    tick();
    host = '0;
    tick();
  endtask
  task automatic start(input logic [2:0] m, input logic [2:0] c, input logic [2:0] w);
    transfer_run = 1'b0;
    transfer_abort = 1'b1;
    tick();
    cfg = '{c, m, w, 1'b0, 1'b0};
    peer.n = 0;
    tick();
    transfer_abort = 1'b0;
    tick();
    transfer_run = 1'b1;
    tick();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_tx;
    wr(3'h0, 8'hA6);
    wr(3'h1, 8'h3C);
    start(MODE_TX8, 3'h5, 3'h1);
    chk(sck_out, 1'b1);
    wait_on(0, 1'b1);
    // The peer sees the last rise a clock late
    tick(2);
    chk(peer.n[15:0], 16'd16);
    chk(peer.cap, 16'h3CA6);
    wait_on(2, 1'b1);
    tick(30);
    chk(sck_out, 1'b1);
    wr(3'h7, 8'h00);
    tick(4);
    chk(status.auto_wait, 1'b0);
    transfer_abort = 1'b1;
    tick();
    chk(status.transfer_active_flag, 1'b0);
  endtask
  task automatic s_stop;
    wr(3'h0, 8'hA5);
    start(MODE_TX4, 3'h4, 3'h0);
    transfer_run = 1'b0;
    wait_on(1, 1'b0);
    tick(2);
    chk(peer.n[15:0], 16'd4);
    chk(peer.cap[15:12], 4'h5);
  endtask
  task automatic s_rx8;
    peer.pat = 16'h5A5A;
    start(MODE_RX8, 3'h2, 3'h0);
    wait_on(0, 1'b1);
    wait_on(2, 1'b1);
    rd(3'h0);
    chk(buf_rdata, 8'h5A);
    tick(3);
    chk(status.auto_wait, 1'b0);
  endtask
  task automatic s_rx4;
    peer.pat = 16'h00B3;
    start(MODE_RX4, 3'h3, 3'h0);
    transfer_run = 1'b0;
    wait_on(1, 1'b0);
    rd(3'h0);
    chk(buf_rdata, 8'h03);
  endtask
  task automatic s_ext;
    wr(3'h0, 8'h96);
    start(MODE_TX8, CLK_EXT, 3'h0);
    chk(sck_oe, 1'b0);
    for (i = 0; i < 40 && status.transfer_active_flag; i++) peer.pulse();
    chk(peer.cap[15:8], DUMMY_WORD);
    chk(status.transfer_active_flag, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    tick(3);
    chk(sck_out, 1'b1);
    chk(so_out, 1'b1);
    chk(status, 3'h0);
    tick(3);
    rst = 1'b0;
    tick();
    start(MODE_TX8, CLK_UNUSED, 3'h0);
    tick(2);
    chk(status.transfer_active_flag, 1'b0);
    s_tx();
    s_stop();
    s_rx8();
    s_rx4();
    s_ext();
    print_verdict();
  end
endmodule
